//--- paet_top.sv
/*
  Process alarm type evaluator: four alarm channels, each with its own
  type code and threshold, compared once per sampling period against
  the process value, set point, MV or remote set point. Also holds the
  loop break detector and the PV change rate source.
  Assumes measurement inputs come from logic on the same clock, and a
  register master that follows the strobe protocol of this code base.
*/
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps

module paet_top #(
  parameter int unsigned SAMPLE_CYCLES = paet_pkg::SAMPLE_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic signed [15:0] process_value,
  input wire logic signed [15:0] set_point,
  input wire logic signed [15:0] manipulated_variable,
  input wire logic signed [15:0] manipulated_variable_cool,
  input wire logic signed [15:0] remote_set_point,
  output logic [3:0] alarm_out,
  output logic sample_tick
);

  // ***********************************************************
  // Helpers
  // ***********************************************************

  // Channel register hit: base page plus word index
  function automatic logic chan_hit(logic [7:0] addr, logic [7:0] base);
    return (addr[7:4] == base[7:4]) && (addr[1:0] == 2'h0);
  endfunction

  // ***********************************************************
  // Declarations
  // ***********************************************************
  localparam int NCH = paet_pkg::NUM_CH;
  localparam logic [22:0] SAMPLE_LAST = 23'(SAMPLE_CYCLES - 1);

  paet_meas_if meas ();

  logic [22:0] tick_cnt_q;
  logic [22:0] tick_cnt_d;
  logic sample_q;
  logic heat_cool_q;
  logic [15:0] lba_time_q;
  logic [15:0] lba_band_q;
  logic [4:0] type_q [NCH];
  logic signed [15:0] thresh_q [NCH];
  logic [NCH-1:0] rearm_q;
  logic [NCH-1:0] alarm_q;
  logic [NCH-1:0] alarm_now;
  logic [NCH-1:0] raw;
  logic signed [15:0] pv_prev_q;
  logic [15:0] lba_cnt_q;
  logic signed [15:0] lba_ref_q;
  logic lba_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // ***********************************************************
  // Register write decode
  // ***********************************************************

  // Write strobes for the shared registers
  wire logic wr_ctrl = reg_write && (reg_addr == paet_pkg::OFS_CTRL);
  wire logic wr_lba_time = reg_write &&
                           (reg_addr == paet_pkg::OFS_LBA_TIME);
  wire logic wr_lba_band = reg_write &&
                           (reg_addr == paet_pkg::OFS_LBA_BAND);
  wire logic wr_type_page = reg_write &&
                            chan_hit(reg_addr, paet_pkg::OFS_TYPE_BASE);
  wire logic wr_thr_page = reg_write &&
                           chan_hit(reg_addr, paet_pkg::OFS_THRESH_BASE);
  wire logic [1:0] wr_ch = reg_addr[3:2];
  // Restart pulse re-arms every standby gate at once
  wire logic restart = wr_ctrl && reg_wdata[paet_pkg::CTRL_RESTART_BIT];
  wire logic [4:0] wtype = reg_wdata[4:0];

  // ***********************************************************
  // Sampling period
  // ***********************************************************

  // one comparison point per sampling period
  assign tick_cnt_d = (tick_cnt_q == SAMPLE_LAST) ? 23'h000000 :
                      tick_cnt_q + 23'h000001;

  // Sample counter and strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      tick_cnt_q <= 23'h000000;
      sample_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      sample_q <= (tick_cnt_q == SAMPLE_LAST);
    end
  end

  // ***********************************************************
  // Shared control registers
  // ***********************************************************

  // Mode, loop break time and band
  always_ff @(posedge clock) begin
    if (reset) begin
      heat_cool_q <= 1'b0;
      lba_time_q <= paet_pkg::LBA_TIME_RST;
      lba_band_q <= paet_pkg::LBA_BAND_RST;
    end else begin
      if (wr_ctrl) begin
        heat_cool_q <= reg_wdata[paet_pkg::CTRL_HEAT_COOL_BIT];
      end
      if (wr_lba_time) begin
        lba_time_q <= reg_wdata[15:0];
      end
      if (wr_lba_band) begin
        lba_band_q <= reg_wdata[15:0];
      end
    end
  end

  // ***********************************************************
  // Per channel registers and evaluation
  // ***********************************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire logic wr_type = wr_type_page && (wr_ch == 2'(g));
      wire logic wr_thr = wr_thr_page && (wr_ch == 2'(g));

      // refused codes are stored as alarm off
      wire logic [4:0] type_in = paet_pkg::paet_type_ok(wtype, 2'(g)) ?
                                 wtype : paet_pkg::TY_OFF;

      // Type and threshold storage; type change re-arms standby
      always_ff @(posedge clock) begin
        if (reset) begin
          type_q[g] <= paet_pkg::TYPE_RST;
          thresh_q[g] <= paet_pkg::THRESH_RST;
          rearm_q[g] <= 1'b0;
        end else begin
          if (wr_type) begin
            type_q[g] <= type_in;
          end
          if (wr_thr) begin
            thresh_q[g] <= reg_wdata[15:0];
          end
          rearm_q[g] <= wr_type || restart;
        end
      end

      paet_alarm_eval u_eval (
        .meas(meas.sink),
        .type_code(type_q[g]),
        .threshold(thresh_q[g]),
        .raw(raw[g])
      );

      paet_standby u_standby (
        .clock(clock),
        .reset(reset),
        .sample(sample_q),
        .rearm(rearm_q[g]),
        .use_standby(paet_pkg::paet_has_standby(type_q[g])),
        .raw(raw[g]),
        .alarm(alarm_now[g])
      );
    end
  endgenerate

  // ***********************************************************
  // Measurement bundle
  // ***********************************************************

  // Inputs pass straight through; same clock, no synchroniser
  assign meas.process_value = process_value;
  assign meas.set_point = set_point;
  assign meas.manipulated_variable = manipulated_variable;
  assign meas.manipulated_variable_cool = manipulated_variable_cool;
  assign meas.remote_set_point = remote_set_point;
  assign meas.heat_cool = heat_cool_q;
  assign meas.loop_break_alarm = lba_q;
  assign meas.pv_rate = 17'({process_value[15], process_value}) -
                        17'({pv_prev_q[15], pv_prev_q});

  // ***********************************************************
  // Change rate and loop break
  // ***********************************************************

  // Heating output pinned at full scale
  wire logic mv_saturated = manipulated_variable >= $signed(paet_pkg::MV_FULL);
  // Rise of PV since the loop break window opened
  wire logic signed [16:0] lba_rise = 17'({process_value[15], process_value})
                                    - 17'({lba_ref_q[15], lba_ref_q});
  wire logic lba_stuck = lba_rise < $signed({1'b0, lba_band_q});
  wire logic lba_due = (lba_time_q != 16'h0000) &&
                       (lba_cnt_q == lba_time_q - 16'h0001);

  // loop break judged once per window of lba_time samples
  always_ff @(posedge clock) begin
    if (reset) begin
      pv_prev_q <= 16'h0000;
      lba_cnt_q <= 16'h0000;
      lba_ref_q <= 16'h0000;
      lba_q <= 1'b0;
    end else if (sample_q) begin
      pv_prev_q <= process_value;
      if (!mv_saturated || (lba_time_q == 16'h0000)) begin
        lba_cnt_q <= 16'h0000;
        lba_ref_q <= process_value;
        lba_q <= 1'b0;
      end else if (lba_due) begin
        lba_cnt_q <= 16'h0000;
        lba_ref_q <= process_value;
        lba_q <= lba_stuck;
      end else begin
        lba_cnt_q <= lba_cnt_q + 16'h0001;
      end
    end
  end

  // ***********************************************************
  // Alarm outputs
  // ***********************************************************

  // outputs change only on a sample strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      alarm_q <= '0;
    end else if (sample_q) begin
      alarm_q <= alarm_now;
    end
  end

  assign alarm_out = alarm_q;
  assign sample_tick = sample_q;

  // ***********************************************************
  // Register read
  // ***********************************************************

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (!reg_read) begin
      rdata_d = 32'h00000000;
    end else if (reg_addr == paet_pkg::OFS_CTRL) begin
      rdata_d[paet_pkg::CTRL_HEAT_COOL_BIT] = heat_cool_q;
    end else if (reg_addr == paet_pkg::OFS_STATUS) begin
      rdata_d[3:0] = alarm_q;
      rdata_d[paet_pkg::STATUS_LBA_BIT] = lba_q;
    end else if (reg_addr == paet_pkg::OFS_LBA_TIME) begin
      rdata_d[15:0] = lba_time_q;
    end else if (reg_addr == paet_pkg::OFS_LBA_BAND) begin
      rdata_d[15:0] = lba_band_q;
    end else if (chan_hit(reg_addr, paet_pkg::OFS_TYPE_BASE)) begin
      rdata_d[4:0] = type_q[reg_addr[3:2]];
    end else if (chan_hit(reg_addr, paet_pkg::OFS_THRESH_BASE)) begin
      rdata_d[15:0] = thresh_q[reg_addr[3:2]];
    end
  end

  // Read data valid in the cycle after the strobe only
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // paet_top

//--- paet_pkg.sv
/*
  Shared constants for the process alarm type evaluator: register map,
  reset values, type codes, sample timing and the type decoding helpers.
  Assumes a 100 MHz clock and 16-bit signed engineering values.
*/
package paet_pkg;

  // ***********************************************************
  // Sizes
  // ***********************************************************
  localparam int NUM_CH = 4;
  localparam int VAL_W = 16;
  localparam int TYPE_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int unsigned CLOCK_NS = 10;
  localparam int unsigned SAMPLE_NS = 50_000_000;
  // Sampling period, exact multiple of the clock period
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_NS / CLOCK_NS;
  localparam int SAMPLE_CNT_W = 23;

  // ***********************************************************
  // Register map (byte addresses)
  // ***********************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LBA_TIME = 8'h08;
  localparam logic [7:0] OFS_LBA_BAND = 8'h0c;
  localparam logic [7:0] OFS_TYPE_BASE = 8'h10;
  localparam logic [7:0] OFS_THRESH_BASE = 8'h20;
  localparam int CTRL_HEAT_COOL_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int STATUS_LBA_BIT = 4;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [4:0] TYPE_RST = 5'h02;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [15:0] LBA_TIME_RST = 16'h0000;
  localparam logic [15:0] LBA_BAND_RST = 16'h0000;
  localparam logic [15:0] MV_FULL = 16'h03e8;

  // ***********************************************************
  // Alarm type codes
  // ***********************************************************
  typedef enum logic [4:0] {
    TY_OFF = 5'h00,
    TY_DEV_HI = 5'h02,
    TY_DEV_LO = 5'h03,
    TY_DEV_HI_SB = 5'h06,
    TY_DEV_LO_SB = 5'h07,
    TY_PV_HI = 5'h08,
    TY_PV_LO = 5'h09,
    TY_PV_HI_SB = 5'h0a,
    TY_PV_LO_SB = 5'h0b,
    TY_LOOP_BREAK = 5'h0c,
    TY_PV_RATE = 5'h0d,
    TY_SP_HI = 5'h0e,
    TY_SP_LO = 5'h0f,
    TY_MV_HI = 5'h10,
    TY_MV_LO = 5'h11,
    TY_RSP_HI = 5'h12,
    TY_RSP_LO = 5'h13
  } paet_type_e;

  // Types that hold the alarm off until first seen clear
  function automatic logic paet_has_standby(logic [4:0] t);
    return (t == TY_DEV_HI_SB) || (t == TY_DEV_LO_SB) ||
           (t == TY_PV_HI_SB) || (t == TY_PV_LO_SB);
  endfunction

  // Codes this block accepts; loop break only on channel 0
  function automatic logic paet_type_ok(logic [4:0] t, logic [1:0] ch);
    return (t == TY_DEV_HI) || (t == TY_DEV_LO) ||
           ((t >= TY_DEV_HI_SB) && (t <= TY_PV_LO_SB)) ||
           ((t == TY_LOOP_BREAK) && (ch == 2'h0)) ||
           ((t >= TY_PV_RATE) && (t <= TY_RSP_LO));
  endfunction

endpackage

//--- paet_meas_if.sv
/*
  Measurement bundle handed from the top to every channel evaluator.
  Assumes all values are sampled on the block clock.
*/
`timescale 1ns/1ps
interface paet_meas_if;
  logic signed [15:0] process_value;
  logic signed [15:0] set_point;
  logic signed [15:0] manipulated_variable;
  logic signed [15:0] manipulated_variable_cool;
  logic signed [15:0] remote_set_point;
  logic signed [16:0] pv_rate;
  logic heat_cool;
  logic loop_break_alarm;
  modport source (
    output process_value, set_point, manipulated_variable,
    output manipulated_variable_cool, remote_set_point, pv_rate,
    output heat_cool, loop_break_alarm
  );
  modport sink (
    input process_value, set_point, manipulated_variable,
    input manipulated_variable_cool, remote_set_point, pv_rate,
    input heat_cool, loop_break_alarm
  );
endinterface // paet_meas_if

//--- paet_alarm_eval.sv
/*
  One channel's level comparison: picks the monitored value and the
  direction from the type code. Purely combinational.
  Assumes the threshold and all values are 16-bit signed.
*/
`timescale 1ns/1ps
module paet_alarm_eval (
  paet_meas_if.sink meas,
  input wire logic [4:0] type_code,
  input wire logic signed [15:0] threshold,
  output logic raw
);

  // Widened operands so sums cannot wrap
  wire logic signed [16:0] pv_w = {meas.process_value[15],
                                  meas.process_value};
  wire logic signed [16:0] sp_w = {meas.set_point[15], meas.set_point};
  wire logic signed [16:0] th_w = {threshold[15], threshold};
  wire logic signed [16:0] dev_hi_lim = sp_w + th_w;
  wire logic signed [16:0] dev_lo_lim = sp_w - th_w;
  // Lower MV limit watches the cooling side under heating/cooling
  wire logic signed [15:0] mv_low_src = meas.heat_cool ?
      meas.manipulated_variable_cool : meas.manipulated_variable;

  // Type selection; unknown codes leave the alarm off
  always_comb begin
    raw = 1'b0;
    case (type_code)
      // deviation high, with or without standby
      paet_pkg::TY_DEV_HI, paet_pkg::TY_DEV_HI_SB: raw = pv_w >= dev_hi_lim;
      // deviation low, with or without standby
      paet_pkg::TY_DEV_LO, paet_pkg::TY_DEV_LO_SB: raw = pv_w <= dev_lo_lim;
      paet_pkg::TY_PV_HI, paet_pkg::TY_PV_HI_SB:
        raw = meas.process_value > threshold;
      paet_pkg::TY_PV_LO, paet_pkg::TY_PV_LO_SB:
        raw = meas.process_value < threshold;
      paet_pkg::TY_LOOP_BREAK: raw = meas.loop_break_alarm;
      // rate of change, sign of threshold picks direction
      paet_pkg::TY_PV_RATE:
        raw = threshold[15] ? (meas.pv_rate < th_w) : (meas.pv_rate > th_w);
      paet_pkg::TY_SP_HI: raw = meas.set_point > threshold;
      paet_pkg::TY_SP_LO: raw = meas.set_point < threshold;
      paet_pkg::TY_MV_HI: raw = meas.manipulated_variable > threshold;
      paet_pkg::TY_MV_LO: raw = mv_low_src < threshold;
      paet_pkg::TY_RSP_HI: raw = meas.remote_set_point > threshold;
      paet_pkg::TY_RSP_LO: raw = meas.remote_set_point < threshold;
      default: raw = 1'b0;
    endcase
  end

endmodule // paet_alarm_eval

//--- paet_standby.sv
/*
  Standby gate for one channel: after start-up or re-arm the alarm is
  held off until a sample finds the condition clear.
  Assumes sample is a one-cycle pulse on the block clock.
*/
`timescale 1ns/1ps
module paet_standby (
  input wire logic clock,
  input wire logic reset,
  input wire logic sample,
  input wire logic rearm,
  input wire logic use_standby,
  input wire logic raw,
  output logic alarm
);

  logic waiting_q;
  logic waiting_d;

  // waiting clears on first clear sample; re-arm wins
  assign waiting_d = rearm ? 1'b1 :
                     (sample && !raw) ? 1'b0 : waiting_q;
  assign alarm = raw && !(use_standby && waiting_q);

  // Waiting flag
  always_ff @(posedge clock) begin
    if (reset) begin
      waiting_q <= 1'b1;
    end else begin
      waiting_q <= waiting_d;
    end
  end

endmodule // paet_standby

//--- paet_top_checker.sv
/*
  Checker for the alarm evaluator top: sample pulse spacing, alarm
  update timing and register read data.
  Assumes it is bound to paet_top and sees only its ports.
*/
`timescale 1ns/1ps
module paet_top_checker #(
  parameter int unsigned SAMPLE_CYCLES = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0] alarm_out,
  input wire logic sample_tick
);
  // ****************************************
  // Cycles since the last sample pulse
  // ****************************************
  logic [31:0] gap_q;
  logic [31:0] gap_d;
  assign gap_d = sample_tick ? 32'h1 : gap_q + 32'h1;
  // Counter clears in reset so the first period is measured too
  always_ff @(posedge clock) begin
    if (reset) begin
      gap_q <= 32'h0;
    end else begin
      gap_q <= gap_d;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_reset_quiet: assert property (disable iff (1'b0) reset |=>
    alarm_out == 4'h0 && reg_rdata == 32'h0 && !sample_tick)
    else $error("outputs not quiet after reset");
  a_tick_period: assert property (
    sample_tick |-> gap_q == SAMPLE_CYCLES)
    else $error("sample pulse off period");
  a_tick_due: assert property (gap_q <= SAMPLE_CYCLES)
    else $error("sample pulse missing");
  a_tick_single: assert property (sample_tick |=> !sample_tick)
    else $error("sample pulse too long");
  a_alarm_hold: assert property (
    !$past(sample_tick) |-> $stable(alarm_out))
    else $error("alarm changed between samples");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data without a read");
  a_status_read: assert property (reg_read && reg_addr == 8'h04 |=>
    reg_rdata[3:0] == $past(alarm_out) && reg_rdata[31:5] == 27'h0)
    else $error("status read differs from alarms");
  a_unmapped_zero: assert property (reg_read &&
    (reg_addr[1:0] != 2'h0 || reg_addr > 8'h2c) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_type_refuse: assert property (reg_write && reg_addr == 8'h14 &&
    reg_wdata[4:0] == 5'h0c ##1 reg_read && reg_addr == 8'h14 |=>
    reg_rdata == 32'h0)
    else $error("loop break accepted off channel 0");
  a_ctrl_read: assert property (reg_read && reg_addr == 8'h00 |=>
    reg_rdata[31:1] == 31'h0)
    else $error("control upper bits not zero");
endmodule // paet_top_checker

bind paet_top paet_top_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
  paet_top_checker_i (.clock(clock), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .alarm_out(alarm_out),
  .sample_tick(sample_tick));

//--- paet_meas_model.sv
/*
  Stand-in for the plant and control loop: holds measured, set point
  and control values and presents them on the block clock.
  Assumes the bench loads a new set with a one-cycle load pulse.
*/
`timescale 1ns/1ps
module paet_meas_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic load,
  input wire logic [79:0] vals_next,
  output logic signed [15:0] process_value,
  output logic signed [15:0] set_point,
  output logic signed [15:0] manipulated_variable,
  output logic signed [15:0] manipulated_variable_cool,
  output logic signed [15:0] remote_set_point
);
  // ****************************************
  // Value store
  // ****************************************
  // Values move only on load, like a converter updating its result
  always_ff @(posedge clock) begin
    if (reset) begin
      {process_value, set_point, manipulated_variable,
       manipulated_variable_cool, remote_set_point} <= 80'h0;
    end else if (load) begin
      {process_value, set_point, manipulated_variable,
       manipulated_variable_cool, remote_set_point} <= vals_next;
    end
  end
endmodule // paet_meas_model

//--- tb_paet_top.sv
/*
  Testbench for the alarm evaluator: walks every type code on channel 0
  through register writes and sampled measurements.
  Assumes a short sampling period set by parameter.
*/
`timescale 1ns/1ps
module tb_paet_top;
  localparam int unsigned SC = 8;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic signed [15:0] pv, sp, mv, mvc, rsp;
  logic [3:0] alarm_out;
  logic sample_tick;
  logic load = 1'b0;
  logic [79:0] vals_next = 80'h0;
  int err_count = 0;
  int n_tests = 0;
  logic [4:0] bad [5] = '{5'h01, 5'h04, 5'h05, 5'h14, 5'h1f};

  // Free running clock
  always #5 clock = ~clock;

  paet_top #(.SAMPLE_CYCLES(SC)) paet_top_i (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .process_value(pv),
    .set_point(sp), .manipulated_variable(mv),
    .manipulated_variable_cool(mvc), .remote_set_point(rsp),
    .alarm_out(alarm_out), .sample_tick(sample_tick));
  paet_meas_model paet_meas_model_i (.clock(clock), .reset(reset),
    .load(load), .vals_next(vals_next), .process_value(pv),
    .set_point(sp), .manipulated_variable(mv),
    .manipulated_variable_cool(mvc), .remote_set_point(rsp));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Optional write, then a read of the same place with no gap
  task automatic access(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [31:0] exp);
    if (w) begin
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  task automatic set_meas(input logic [15:0] p, s, m, c, r);
    @(posedge clock);
    vals_next <= {p, s, m, c, r};
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
  endtask

  // Returns in the cycle where the sample pulse stands
  task automatic wait_tick();
    int k;
    k = 0;
    do begin
      @(posedge clock);
      #1;
      k++;
    end while (sample_tick !== 1'b1 && k < 40);
    if (sample_tick !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: no sample pulse", $time);
    end
  endtask

  // Measurements first, so the first sample after a standby re-arm sees them
  task automatic row(input logic [4:0] ty, input logic [15:0] thr,
      input logic [15:0] p, s, m, c, r, input logic [2:0] f);
    logic [4:0] kept;
    kept = (ty inside {5'h02, 5'h03, [5'h06:5'h13]}) ? ty : 5'h00;
    set_meas(p, s, m, c, r);
    if (f[1]) begin
      access(1'b1, 8'h00, {31'h0, f[2]}, {31'h0, f[2]});
      access(1'b1, 8'h20, {16'h0, thr}, {16'h0, thr});
      access(1'b1, 8'h10, {27'h0, ty}, {27'h0, kept});
    end
    wait_tick();
    @(posedge clock);
    #1;
    check({31'h0, alarm_out[0]}, {31'h0, f[0]});
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      access(1'b0, 8'h10 + 8'(4 * i), 32'h0, 32'h2);
      access(1'b0, 8'h20 + 8'(4 * i), 32'h0, 32'h0);
    end
    access(1'b1, 8'h30, 32'hffffffff, 32'h0);
    access(1'b1, 8'h11, 32'hffffffff, 32'h0);
    access(1'b1, 8'h14, 32'hc, 32'h0);
    access(1'b1, 8'h00, 32'h3, 32'h1);
    row(5'h02, 16'ha, 16'h6e, 16'h64, 16'h0, 16'h0, 16'h0, 3'b011);
    row(5'h02, 16'ha, 16'h6d, 16'h64, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h03, 16'ha, 16'h5a, 16'h64, 16'h0, 16'h0, 16'h0, 3'b011);
    row(5'h03, 16'ha, 16'h5b, 16'h64, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h08, 16'h32, 16'h33, 16'h0, 16'h0, 16'h0, 16'h0, 3'b011);
    row(5'h08, 16'h32, 16'h32, 16'h0, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h08, 16'hfffb, 16'hfffc, 16'h0, 16'h0, 16'h0, 16'h0, 3'b011);
    row(5'h09, 16'h32, 16'h31, 16'h0, 16'h0, 16'h0, 16'h0, 3'b011);
    row(5'h09, 16'h32, 16'h32, 16'h0, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h0e, 16'h32, 16'h0, 16'h33, 16'h0, 16'h0, 16'h0, 3'b011);
    row(5'h0e, 16'h32, 16'h0, 16'h32, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h0f, 16'h32, 16'h0, 16'h31, 16'h0, 16'h0, 16'h0, 3'b011);
    row(5'h10, 16'h32, 16'h0, 16'h0, 16'h33, 16'h0, 16'h0, 3'b011);
    row(5'h10, 16'h32, 16'h0, 16'h0, 16'h32, 16'h0, 16'h0, 3'b000);
    row(5'h10, 16'h32, 16'h0, 16'h0, 16'h33, 16'h0, 16'h0, 3'b111);
    row(5'h10, 16'h32, 16'h0, 16'h0, 16'h28, 16'h3c, 16'h0, 3'b100);
    row(5'h11, 16'h32, 16'h0, 16'h0, 16'h31, 16'h0, 16'h0, 3'b011);
    row(5'h11, 16'h32, 16'h0, 16'h0, 16'ha, 16'h3c, 16'h0, 3'b110);
    row(5'h11, 16'h32, 16'h0, 16'h0, 16'h3c, 16'h28, 16'h0, 3'b101);
    row(5'h12, 16'h32, 16'h0, 16'h0, 16'h0, 16'h0, 16'h33, 3'b011);
    row(5'h12, 16'h32, 16'h0, 16'h0, 16'h0, 16'h0, 16'h32, 3'b000);
    row(5'h13, 16'h32, 16'h0, 16'h0, 16'h0, 16'h0, 16'h31, 3'b011);
    row(5'h06, 16'ha, 16'h78, 16'h64, 16'h0, 16'h0, 16'h0, 3'b010);
    row(5'h06, 16'ha, 16'h78, 16'h64, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h06, 16'ha, 16'h64, 16'h64, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h06, 16'ha, 16'h78, 16'h64, 16'h0, 16'h0, 16'h0, 3'b001);
    row(5'h07, 16'ha, 16'h50, 16'h64, 16'h0, 16'h0, 16'h0, 3'b010);
    row(5'h07, 16'ha, 16'h64, 16'h64, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h07, 16'ha, 16'h50, 16'h64, 16'h0, 16'h0, 16'h0, 3'b001);
    row(5'h0a, 16'h32, 16'h3c, 16'h0, 16'h0, 16'h0, 16'h0, 3'b010);
    row(5'h0a, 16'h32, 16'h28, 16'h0, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h0a, 16'h32, 16'h3c, 16'h0, 16'h0, 16'h0, 16'h0, 3'b001);
    row(5'h0b, 16'h32, 16'h28, 16'h0, 16'h0, 16'h0, 16'h0, 3'b010);
    row(5'h0b, 16'h32, 16'h3c, 16'h0, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h0b, 16'h32, 16'h28, 16'h0, 16'h0, 16'h0, 16'h0, 3'b001);
    access(1'b1, 8'h00, 32'h2, 32'h0);
    row(5'h0b, 16'h32, 16'h28, 16'h0, 16'h0, 16'h0, 16'h0, 3'b000);
    row(5'h0d, 16'h5, 16'h28, 16'h0, 16'h0, 16'h0, 16'h0, 3'b010);
    row(5'h0d, 16'h5, 16'h32, 16'h0, 16'h0, 16'h0, 16'h0, 3'b001);
    row(5'h0d, 16'h5, 16'h34, 16'h0, 16'h0, 16'h0, 16'h0, 3'b000);
    foreach (bad[i]) begin
      row(bad[i], 16'h0, 16'h6e, 16'h64, 16'h6e, 16'h0, 16'h6e, 3'b010);
    end
    access(1'b1, 8'h08, 32'h2, 32'h2);
    access(1'b1, 8'h0c, 32'h5, 32'h5);
    access(1'b1, 8'h10, 32'hc, 32'hc);
    set_meas(16'h64, 16'h0, 16'h3e8, 16'h0, 16'h0);
    repeat (5) wait_tick();
    row(5'h0c, 16'h0, 16'h64, 16'h0, 16'h3e8, 16'h0, 16'h0, 3'b001);
    access(1'b0, 8'h04, 32'h0, 32'h1d);
    check({28'h0, alarm_out}, 32'hd);
    set_meas(16'h64, 16'h0, 16'h0, 16'h0, 16'h0);
    wait_tick();
    row(5'h0c, 16'h0, 16'h64, 16'h0, 16'h0, 16'h0, 16'h0, 3'b000);
    close_out();
  end

  // Watchdog, well beyond the thousand or so cycles the tests need
  initial begin
    #200000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
endmodule // tb_paet_top
